// [common/sp0_cfg.svh]
`ifndef SP0_CFG_SVH
`define SP0_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define SP0_OFF_POWER_CONTROL 8'h87
`define SP0_OFF_SERIAL_CONTROL 8'h98
`define SP0_OFF_SERIAL_DATA_BUFFER 8'h99

// ****************************************
// Field positions
// ****************************************
`define SP0_PC_BAUD_DOUBLER 7
`define SP0_PC_FRAMING_SEL 6
`define SP0_PC_POWER_DOWN 1
`define SP0_PC_IDLE 0
`define SP0_PC_WRITE_MASK 8'hcf

`define SP0_SC_MODE_HI 7
`define SP0_SC_MODE_LO 6
`define SP0_SC_MP_EN 5
`define SP0_SC_RX_EN 4
`define SP0_SC_TX9 3
`define SP0_SC_RX9 2
`define SP0_SC_TX_DONE 1
`define SP0_SC_RX_DONE 0

// ****************************************
// Reset values
// ****************************************
`define SP0_POWER_CONTROL_RST 8'h00
`define SP0_SERIAL_CONTROL_RST 8'h00
`define SP0_DATA_RST 8'h00

// ****************************************
// Timing, in core clock periods or divisions
// ****************************************
`define SP0_M0_DIV_SLOW 12
`define SP0_M0_DIV_FAST 4
`define SP0_M2_DIV_NORM 64
`define SP0_M2_DIV_DBL 32
`define SP0_EXT_DIV_NORM 32
`define SP0_EXT_DIV_DBL 16
`define SP0_OVERSAMPLE 16

`endif

// [common/sp0_pkg.sv]
package sp0_pkg;

	typedef enum logic [1:0] {
		SP0_MODE_SYNC,
		SP0_MODE_ASYNC10,
		SP0_MODE_FIXED11,
		SP0_MODE_VAR11
	} sp0_mode_e;

	typedef enum {
		SP0_TX_IDLE,
		SP0_TX_ASYNC,
		SP0_TX_SYNC
	} sp0_tx_state_e;

	typedef enum {
		SP0_RX_IDLE,
		SP0_RX_ASYNC,
		SP0_RX_SYNC
	} sp0_rx_state_e;

endpackage

// [rtl/sp0_baud.sv]
`timescale 1ns/100ps
`include "sp0_cfg.svh"

module sp0_baud import sp0_pkg::*; #(
	parameter int OVERSAMPLE = `SP0_OVERSAMPLE
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic run,
	input wire sp0_mode_e mode,
	input wire logic baud_doubler,
	input wire logic multiproc_enable,
	input wire logic ext_tick,
	output logic os_tick,
	output logic half_tick
);
	localparam int PW = 6;
	localparam logic [PW-1:0] M0_SLOW = PW'(`SP0_M0_DIV_SLOW / 2 - 1);
	localparam logic [PW-1:0] M0_FAST = PW'(`SP0_M0_DIV_FAST / 2 - 1);
	localparam logic [PW-1:0] M2_NORM = PW'(`SP0_M2_DIV_NORM / OVERSAMPLE - 1);
	localparam logic [PW-1:0] M2_DBL = PW'(`SP0_M2_DIV_DBL / OVERSAMPLE - 1);
	localparam logic [PW-1:0] EXT_NORM = PW'(`SP0_EXT_DIV_NORM / OVERSAMPLE - 1);
	localparam logic [PW-1:0] EXT_DBL = PW'(`SP0_EXT_DIV_DBL / OVERSAMPLE - 1);

	if (OVERSAMPLE < 4 || (OVERSAMPLE & (OVERSAMPLE - 1)) != 0 ||
		(`SP0_M2_DIV_DBL % OVERSAMPLE) != 0 || (`SP0_EXT_DIV_DBL % OVERSAMPLE) != 0) begin : g_bad
		$error("sp0_baud: OVERSAMPLE must be a power of two dividing the bit dividers");
	end

	logic [PW-1:0] pre_q, pre_d;
	logic [PW-1:0] ext_q, ext_d;
	logic [PW-1:0] limit;
	logic [PW-1:0] ext_limit;
	logic wrap;

	// ****************************************
	// Prescalers
	// ****************************************
	always_comb begin
		pre_d = pre_q;
		ext_d = ext_q;
		os_tick = 1'b0;
		half_tick = 1'b0;
		if (mode == SP0_MODE_SYNC) begin
			limit = multiproc_enable ? M0_FAST : M0_SLOW;
		end else begin
			limit = baud_doubler ? M2_DBL : M2_NORM;
		end
		ext_limit = baud_doubler ? EXT_DBL : EXT_NORM;
		wrap = (pre_q >= limit);
		if (!run) begin
			// Power-down freezes the serial clock entirely
			pre_d = '0;
			ext_d = '0;
		end else begin
			pre_d = wrap ? '0 : pre_q + 1'b1;
			unique case (mode)
				SP0_MODE_SYNC: half_tick = wrap;
				SP0_MODE_FIXED11: os_tick = wrap;
				SP0_MODE_ASYNC10, SP0_MODE_VAR11: begin
					if (ext_tick) begin
						ext_d = (ext_q >= ext_limit) ? '0 : ext_q + 1'b1;
						os_tick = (ext_q >= ext_limit);
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pre_q <= '0;
			ext_q <= '0;
		end else begin
			pre_q <= pre_d;
			ext_q <= ext_d;
		end
	end
endmodule

// [rtl/sp0_uart.sv]
// Chosen here: strobed register access.
`timescale 1ns/100ps
`include "sp0_cfg.svh"

// ****************************************
// Serial port zero
// ****************************************
// Behaviour
// - Baud doubler set doubles the bit rate in modes 1, 2 and 3.
// - Framing check select makes control bit 7 the framing error flag, else mode high.
// - Invalid received stop bit sets framing error; only software clears it.
// - Mode bits pick sync 8-bit, async 10-bit, fixed 11-bit or variable 11-bit.
// - Modes 2 and 3 with multiprocessor enable: no receive done if ninth bit 0.
// - Mode 1 with multiprocessor enable: no receive done without valid stop bit.
// - Mode 0 shift clock is clock/12, or clock/4 with multiprocessor enable.
// - Reception only happens while receive enable is set.
// - Modes 2 and 3 send the software ninth bit as the tenth frame bit.
// - Receive ninth bit takes ninth data bit, or stop bit in mode 1.
// - Transmit done sets after eighth bit in mode 0, else at stop start.
// - Receive done sets after eighth bit in mode 0, else mid stop bit.
// - Data buffer read gives receive register; write loads transmit buffer.
// - Idle request leaves the serial port running.
// - Power-down request halts all serial activity until wake.
module sp0_uart import sp0_pkg::*; #(
	parameter int OVERSAMPLE = `SP0_OVERSAMPLE
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [7:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire logic ext_baud_tick,
	input wire logic wake_req,
	input wire logic rxd_in,
	output logic rxd_out,
	output logic rxd_oe,
	output logic txd_out,
	output logic idle_mode,
	output logic power_down_mode
);
	localparam int CW = $clog2(OVERSAMPLE);
	localparam logic [CW-1:0] OS_MID = CW'(OVERSAMPLE / 2 - 1);
	localparam logic [CW-1:0] OS_LAST = CW'(OVERSAMPLE - 1);

	logic [7:0] pwr_q, pwr_d;
	logic [7:0] serial_control_q, serial_control_d;
	logic fe_q, fe_d;
	logic [7:0] tx_buf_q, tx_buf_d;
	logic [7:0] rx_buf_q, rx_buf_d;
	logic [7:0] rdata_q, rdata_d;
	sp0_mode_e mode;
	logic run, fcs, os_tick, half_tick, serial_data_buffer_wr;
	logic tx_done_set, rx_take, rx_ninth, fe_set;
	sp0_tx_state_e tx_state_q, tx_state_d;
	logic [7:0] rx_shift_q, rx_shift_d;
	logic sync_kick, baud_run;

	assign mode = sp0_mode_e'(serial_control_q[`SP0_SC_MODE_HI:`SP0_SC_MODE_LO]);
	assign fcs = pwr_q[`SP0_PC_FRAMING_SEL];
	// Idle is only reported outward; the serial clock keeps running
	assign run = !pwr_q[`SP0_PC_POWER_DOWN];
	// Restart the divider on a sync send so the first clock half is full length
	assign sync_kick = serial_data_buffer_wr && (mode == SP0_MODE_SYNC) && (tx_state_q == SP0_TX_IDLE);
	assign baud_run = run && !sync_kick;
	assign serial_data_buffer_wr = bus_wr && (bus_addr == `SP0_OFF_SERIAL_DATA_BUFFER);
	assign bus_rdata = rdata_q;
	assign idle_mode = pwr_q[`SP0_PC_IDLE];
	assign power_down_mode = pwr_q[`SP0_PC_POWER_DOWN];

	sp0_baud #(
		.OVERSAMPLE(OVERSAMPLE)
	) u_baud (
		.core_clk(core_clk),
		.rstn(rstn),
		.run(baud_run),
		.mode(mode),
		.baud_doubler(pwr_q[`SP0_PC_BAUD_DOUBLER]),
		.multiproc_enable(serial_control_q[`SP0_SC_MP_EN]),
		.ext_tick(ext_baud_tick),
		.os_tick(os_tick),
		.half_tick(half_tick)
	);

	// ****************************************
	// Registers
	// ****************************************
	always_comb begin
		pwr_d = pwr_q;
		serial_control_d = serial_control_q;
		fe_d = fe_q;
		tx_buf_d = tx_buf_q;
		rx_buf_d = rx_buf_q;
		rdata_d = 8'h00;
		if (bus_rd) begin
			case (bus_addr)
				`SP0_OFF_POWER_CONTROL: rdata_d = pwr_q;
				`SP0_OFF_SERIAL_CONTROL: rdata_d = {fcs ? fe_q : serial_control_q[7], serial_control_q[6:0]};
				`SP0_OFF_SERIAL_DATA_BUFFER: rdata_d = rx_buf_q;
				default: rdata_d = 8'h00;
			endcase
		end
		if (bus_wr) begin
			case (bus_addr)
				`SP0_OFF_POWER_CONTROL: pwr_d = bus_wdata & `SP0_PC_WRITE_MASK;
				`SP0_OFF_SERIAL_CONTROL: begin
					serial_control_d[6:0] = bus_wdata[6:0];
					if (fcs) begin
						fe_d = bus_wdata[7];
					end else begin
						serial_control_d[7] = bus_wdata[7];
					end
				end
				`SP0_OFF_SERIAL_DATA_BUFFER: tx_buf_d = bus_wdata;
				default: ;
			endcase
		end
		if (wake_req) begin
			pwr_d[`SP0_PC_POWER_DOWN] = 1'b0;
			pwr_d[`SP0_PC_IDLE] = 1'b0;
		end
		// Hardware sets come last so an event beats a same-cycle clear
		if (tx_done_set) begin
			serial_control_d[`SP0_SC_TX_DONE] = 1'b1;
		end
		if (fe_set) begin
			fe_d = 1'b1;
		end
		if (rx_take) begin
			serial_control_d[`SP0_SC_RX_DONE] = 1'b1;
			rx_buf_d = rx_shift_q;
			if (mode != SP0_MODE_SYNC) begin
				serial_control_d[`SP0_SC_RX9] = rx_ninth;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pwr_q <= `SP0_POWER_CONTROL_RST;
			serial_control_q <= `SP0_SERIAL_CONTROL_RST;
			fe_q <= 1'b0;
			tx_buf_q <= `SP0_DATA_RST;
			rx_buf_q <= `SP0_DATA_RST;
			rdata_q <= 8'h00;
		end else begin
			pwr_q <= pwr_d;
			serial_control_q <= serial_control_d;
			fe_q <= fe_d;
			tx_buf_q <= tx_buf_d;
			rx_buf_q <= rx_buf_d;
			rdata_q <= rdata_d;
		end
	end

	// ****************************************
	// Transmitter
	// ****************************************
	logic [10:0] tx_shift_q, tx_shift_d;
	logic [3:0] tx_bits_q, tx_bits_d;
	logic [CW-1:0] tx_os_q, tx_os_d;
	logic tx_half_q, tx_half_d;
	logic tx_line_d, rxd_out_d, rxd_oe_d;

	always_comb begin
		tx_state_d = tx_state_q;
		tx_shift_d = tx_shift_q;
		tx_bits_d = tx_bits_q;
		tx_os_d = tx_os_q;
		tx_half_d = tx_half_q;
		tx_line_d = 1'b1;
		rxd_out_d = rxd_out;
		rxd_oe_d = rxd_oe;
		tx_done_set = 1'b0;
		unique case (tx_state_q)
			SP0_TX_IDLE: begin
				rxd_oe_d = 1'b0;
				if (serial_data_buffer_wr && run) begin
					tx_os_d = '0;
					tx_half_d = 1'b0;
					if (mode == SP0_MODE_SYNC) begin
						// Count here includes the bit on the pin
						tx_state_d = SP0_TX_SYNC;
						tx_shift_d = {3'b111, bus_wdata};
						tx_bits_d = 4'd8;
						rxd_out_d = bus_wdata[0];
						rxd_oe_d = 1'b1;
						tx_line_d = 1'b0;
					end else begin
						// Count here is bits still to follow the start bit
						tx_state_d = SP0_TX_ASYNC;
						tx_shift_d = {1'b1, (mode == SP0_MODE_ASYNC10) ? 1'b1 :
							serial_control_q[`SP0_SC_TX9], bus_wdata, 1'b0};
						tx_bits_d = (mode == SP0_MODE_ASYNC10) ? 4'd9 : 4'd10;
						tx_line_d = 1'b0;
					end
				end
			end
			SP0_TX_ASYNC: begin
				tx_line_d = tx_shift_q[0];
				if (os_tick) begin
					tx_os_d = tx_os_q + 1'b1;
					if (tx_os_q == OS_LAST) begin
						if (tx_bits_q == 4'd0) begin
							tx_state_d = SP0_TX_IDLE;
							tx_line_d = 1'b1;
						end else begin
							tx_shift_d = {1'b1, tx_shift_q[10:1]};
							tx_bits_d = tx_bits_q - 1'b1;
							tx_line_d = tx_shift_d[0];
							tx_done_set = (tx_bits_q == 4'd1);
						end
					end
				end
			end
			SP0_TX_SYNC: begin
				tx_line_d = tx_half_q;
				if (half_tick) begin
					if (!tx_half_q) begin
						tx_half_d = 1'b1;
						tx_line_d = 1'b1;
					end else if (tx_bits_q == 4'd1) begin
						tx_state_d = SP0_TX_IDLE;
						tx_done_set = 1'b1;
						rxd_oe_d = 1'b0;
						tx_line_d = 1'b1;
					end else begin
						tx_shift_d = {1'b1, tx_shift_q[10:1]};
						tx_bits_d = tx_bits_q - 1'b1;
						rxd_out_d = tx_shift_d[0];
						tx_half_d = 1'b0;
						tx_line_d = 1'b0;
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tx_state_q <= SP0_TX_IDLE;
			tx_shift_q <= '1;
			tx_bits_q <= 4'h0;
			tx_os_q <= '0;
			tx_half_q <= 1'b0;
			rxd_out <= 1'b1;
			rxd_oe <= 1'b0;
		end else begin
			tx_state_q <= tx_state_d;
			tx_shift_q <= tx_shift_d;
			tx_bits_q <= tx_bits_d;
			tx_os_q <= tx_os_d;
			tx_half_q <= tx_half_d;
			rxd_out <= rxd_out_d;
			rxd_oe <= rxd_oe_d;
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	sp0_rx_state_e rx_state_q, rx_state_d;
	logic [3:0] rx_idx_q, rx_idx_d;
	logic [3:0] rx_last;
	logic [CW-1:0] rx_os_q, rx_os_d;
	logic rx_half_q, rx_half_d;
	logic rx_nine_q, rx_nine_d;
	logic rx_prev_q;
	logic rx_sclk_d;
	logic rx_en;

	assign rx_en = serial_control_q[`SP0_SC_RX_EN];
	assign rx_last = (mode == SP0_MODE_ASYNC10) ? 4'd9 : 4'd10;

	always_comb begin
		rx_state_d = rx_state_q;
		rx_shift_d = rx_shift_q;
		rx_idx_d = rx_idx_q;
		rx_os_d = rx_os_q;
		rx_half_d = rx_half_q;
		rx_nine_d = rx_nine_q;
		rx_sclk_d = 1'b1;
		rx_take = 1'b0;
		rx_ninth = rx_nine_q;
		fe_set = 1'b0;
		unique case (rx_state_q)
			SP0_RX_IDLE: begin
				if (run && rx_en) begin
					if (mode == SP0_MODE_SYNC) begin
						// Sync receive waits for a free line and an empty buffer
						if (!serial_control_q[`SP0_SC_RX_DONE] && tx_state_q == SP0_TX_IDLE && !serial_data_buffer_wr) begin
							rx_state_d = SP0_RX_SYNC;
							rx_idx_d = 4'd0;
							rx_half_d = 1'b0;
							rx_sclk_d = 1'b0;
						end
					end else if (rx_prev_q && !rxd_in) begin
						rx_state_d = SP0_RX_ASYNC;
						rx_idx_d = 4'd0;
						rx_os_d = '0;
					end
				end
			end
			SP0_RX_ASYNC: begin
				if (!rx_en) begin
					rx_state_d = SP0_RX_IDLE;
				end else if (os_tick) begin
					rx_os_d = rx_os_q + 1'b1;
					if (rx_os_q == OS_MID) begin
						rx_idx_d = rx_idx_q + 1'b1;
						if (rx_idx_q == 4'd0) begin
							// A glitch shorter than half a bit is not a start
							if (rxd_in) begin
								rx_state_d = SP0_RX_IDLE;
							end
						end else if (rx_idx_q == rx_last) begin
							rx_state_d = SP0_RX_IDLE;
							fe_set = !rxd_in;
							if (mode == SP0_MODE_ASYNC10) begin
								rx_ninth = rxd_in;
								rx_take = !serial_control_q[`SP0_SC_MP_EN] || rxd_in;
							end else begin
								rx_take = !serial_control_q[`SP0_SC_MP_EN] || rx_nine_q;
							end
						end else if (rx_idx_q == 4'd9) begin
							rx_nine_d = rxd_in;
						end else begin
							rx_shift_d = {rxd_in, rx_shift_q[7:1]};
						end
					end
				end
			end
			SP0_RX_SYNC: begin
				rx_sclk_d = rx_half_q;
				if (!rx_en) begin
					rx_state_d = SP0_RX_IDLE;
				end else if (half_tick) begin
					if (!rx_half_q) begin
						rx_half_d = 1'b1;
						rx_sclk_d = 1'b1;
						rx_shift_d = {rxd_in, rx_shift_q[7:1]};
					end else if (rx_idx_q == 4'd7) begin
						rx_state_d = SP0_RX_IDLE;
						rx_take = 1'b1;
					end else begin
						rx_idx_d = rx_idx_q + 1'b1;
						rx_half_d = 1'b0;
						rx_sclk_d = 1'b0;
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rx_state_q <= SP0_RX_IDLE;
			rx_shift_q <= 8'h00;
			rx_idx_q <= 4'h0;
			rx_os_q <= '0;
			rx_half_q <= 1'b0;
			rx_nine_q <= 1'b0;
			rx_prev_q <= 1'b1;
			txd_out <= 1'b1;
		end else begin
			rx_state_q <= rx_state_d;
			rx_shift_q <= rx_shift_d;
			rx_idx_q <= rx_idx_d;
			rx_os_q <= rx_os_d;
			rx_half_q <= rx_half_d;
			rx_nine_q <= rx_nine_d;
			rx_prev_q <= rxd_in;
			txd_out <= (rx_state_d == SP0_RX_SYNC) ? rx_sclk_d : tx_line_d;
		end
	end
endmodule

// [tb/sp0_peer.sv]
`timescale 1ns/100ps
// ****
// Far-end serial node
// ****
module sp0_peer (
	input wire logic core_clk,
	input wire logic txd,
	output logic rxd
);
	logic [10:0] got;
	// Line has a pull-up, so it sits high between frames
	initial rxd = 1'b1;
	task automatic send(input logic [10:0] f, input int n);
		@(posedge core_clk);
		for (int i = 0; i < n; i++) begin
			rxd <= f[i];
			repeat (64) @(posedge core_clk);
		end
		rxd <= 1'b1;
	endtask
	// Sync receive: next bit after each falling shift clock
	task automatic feed(input logic [7:0] b);
		@(posedge core_clk);
		rxd <= b[0];
		@(negedge txd);
		for (int i = 1; i < 8; i++) begin
			@(negedge txd);
			rxd <= b[i];
		end
	endtask
	// Mid-bit sampling, LSB first
	task automatic grab(input int bt);
		@(negedge txd);
		repeat (bt / 2) @(posedge core_clk);
		for (int i = 0; i < 11; i++) begin
			got[i] = txd;
			repeat (bt) @(posedge core_clk);
		end
	endtask
endmodule

// [tb/sp0_uart_properties.sv]
`timescale 1ns/100ps
// ****
// Port checks
// ****
module sp0_uart_chk #(
	parameter int OVERSAMPLE = 16
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [7:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic ext_baud_tick,
	input wire logic wake_req,
	input wire logic rxd_in,
	input wire logic rxd_out,
	input wire logic rxd_oe,
	input wire logic txd_out,
	input wire logic idle_mode,
	input wire logic power_down_mode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	logic fcs_q, hi_q, lo_q;
	// Shadow of the mode bits: a sync receive clock has short low halves
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fcs_q <= 1'b0;
			hi_q <= 1'b0;
			lo_q <= 1'b0;
		end else if (bus_wr && bus_addr == 8'h87) begin
			fcs_q <= bus_wdata[6];
		end else if (bus_wr && bus_addr == 8'h98) begin
			lo_q <= bus_wdata[6];
			hi_q <= fcs_q ? hi_q : bus_wdata[7];
		end
	end
	rdata_quiet_a: assert property (!bus_rd |=> bus_rdata == 8'h00)
		else $error("stray read data");
	hole_read_a: assert property (bus_rd && !(bus_addr inside {8'h87, 8'h98, 8'h99})
		|=> bus_rdata == 8'h00) else $error("unmapped read not zero");
	sleep_bits_a: assert property (bus_wr && bus_addr == 8'h87 && !wake_req |=>
		idle_mode == $past(bus_wdata[0]) && power_down_mode == $past(bus_wdata[1]))
		else $error("sleep bits wrong");
	wake_clear_a: assert property (wake_req && !bus_wr |=> !idle_mode && !power_down_mode)
		else $error("wake did not clear");
	freeze_line_a: assert property (power_down_mode |=> $stable(txd_out) && $stable(rxd_oe))
		else $error("line moved in power-down");
	start_len_a: assert property ($fell(txd_out) && !rxd_oe && (hi_q || lo_q) |->
		(!txd_out)[*8])
		else $error("start bit too short");
	shift_low_a: assert property ($fell(txd_out) && rxd_oe |-> (!txd_out)[*2] ##[1:5] txd_out)
		else $error("shift clock half wrong");
	oe_done_a: assert property ($fell(rxd_oe) |-> txd_out)
		else $error("shift clock not idle");
endmodule

bind sp0_uart sp0_uart_chk #(.OVERSAMPLE(OVERSAMPLE)) u_chk (
	.core_clk(core_clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
	.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ext_baud_tick(ext_baud_tick),
	.wake_req(wake_req), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
	.txd_out(txd_out), .idle_mode(idle_mode), .power_down_mode(power_down_mode)
);

// [tb/tb_top.sv]
`timescale 1ns/100ps
`include "sp0_cfg.svh"
// ****
// Serial port zero bench
// ****
module tb_top;
	localparam logic [7:0] PC = `SP0_OFF_POWER_CONTROL;
	localparam logic [7:0] SC = `SP0_OFF_SERIAL_CONTROL;
	localparam logic [7:0] DB = `SP0_OFF_SERIAL_DATA_BUFFER;
	logic core_clk = 1'b0, rstn = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
	logic ext_baud_tick = 1'b0, wake_req = 1'b0;
	logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata, v, d;
	logic rxd_out, rxd_oe, txd_out, idle_mode, power_down_mode, peer_rxd, rxd_in;
	int bad_count = 0, num_checks = 0, cyc = 0, w;
	always #10 core_clk = ~core_clk;
	// Overflow every second clock: 64 clocks a bit in modes 1 and 3
	always @(posedge core_clk) ext_baud_tick <= ~ext_baud_tick;
	assign rxd_in = rxd_oe ? rxd_out : peer_rxd;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	sp0_uart dut (
		.core_clk(core_clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ext_baud_tick(ext_baud_tick),
		.wake_req(wake_req), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
		.txd_out(txd_out), .idle_mode(idle_mode), .power_down_mode(power_down_mode)
	);
	sp0_peer peer (.core_clk(core_clk), .txd(txd_out), .rxd(peer_rxd));
	task automatic wr(input logic [7:0] a, input logic [7:0] dv);
		@(posedge core_clk);
		bus_addr <= a;
		bus_wdata <= dv;
		bus_wr <= 1'b1;
		@(posedge core_clk);
		bus_wr <= 1'b0;
	endtask
	task automatic chk(input logic [10:0] g, input logic [10:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		#1;
		chk({3'h0, bus_rdata}, {3'h0, e});
	endtask
	task automatic tally_and_finish();
		$display("%0d checks, %0d mismatches", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic t_regs();
		rdc(PC, 8'h00);
		rdc(SC, 8'h00);
		rdc(DB, 8'h00);
		wr(8'h9a, 8'hff);
		rdc(8'h9a, 8'h00);
		wr(PC, 8'hff);
		rdc(PC, 8'hcf);
		wr(DB, 8'h3c);
		repeat (30) @(posedge core_clk);
		#1;
		chk({10'h000, rxd_oe}, 11'h000);
		@(posedge core_clk);
		wake_req <= 1'b1;
		@(posedge core_clk);
		wake_req <= 1'b0;
		rdc(PC, 8'hcc);
		wr(PC, 8'h00);
		$display("test regs done");
	endtask
	task automatic t_tx();
		logic [1:0] m;
		for (int j = 0; j < 4; j++) begin
			m = (j == 3) ? 2'h2 : 2'(j + 1);
			d = 8'ha5 ^ 8'(j);
			wr(PC, (j == 3) ? 8'h81 : 8'h01);
			wr(SC, {m, 2'h0, j[0], 3'h0});
			fork
				peer.grab((j == 3) ? 32 : 64);
				wr(DB, d);
			join
			chk(peer.got, {1'b1, j[0] | (m == 2'h1), d, 1'b0});
			rdc(SC, {m, 2'h0, j[0], 3'h2});
		end
		wr(PC, 8'h00);
		$display("test tx done");
	endtask
	task automatic t_rx();
		wr(SC, 8'hb0);
		peer.send({2'h2, 8'h3c, 1'b0}, 11);
		rdc(SC, 8'hb0);
		peer.send({2'h3, 8'hc3, 1'b0}, 11);
		rdc(SC, 8'hb5);
		rdc(DB, 8'hc3);
		wr(SC, 8'h80);
		peer.send({2'h3, 8'h66, 1'b0}, 11);
		rdc(SC, 8'h80);
		rdc(DB, 8'hc3);
		$display("test rx done");
	endtask
	task automatic t_fe();
		wr(SC, 8'h70);
		wr(PC, 8'h40);
		peer.send({2'h2, 8'h77, 1'b0}, 10);
		rdc(SC, 8'hf0);
		peer.send({2'h3, 8'h69, 1'b0}, 10);
		rdc(SC, 8'hf5);
		rdc(DB, 8'h69);
		wr(SC, 8'h70);
		rdc(SC, 8'h70);
		wr(PC, 8'h00);
		$display("test framing done");
	endtask
	task automatic t_m0();
		for (int k = 0; k < 2; k++) begin
			wr(SC, k ? 8'h20 : 8'h00);
			wr(DB, 8'h96);
			#1;
			w = 0;
			v = 8'h00;
			for (int b = 0; b < 8; b++) begin
				for (int i = 0; i < 20 && txd_out !== 1'b1; i++) begin
					@(posedge core_clk);
					#1;
					w += (b == 0);
				end
				v = {rxd_out, v[7:1]};
				for (int i = 0; i < 20 && txd_out !== 1'b0 && b < 7; i++) begin
					@(posedge core_clk);
					#1;
				end
			end
			chk(11'(w), k ? 11'h002 : 11'h006);
			chk({3'h0, v}, 11'h096);
			repeat (8) @(posedge core_clk);
			#1;
			rdc(SC, k ? 8'h22 : 8'h02);
		end
		$display("test sync done");
	endtask
	task automatic t_m0rx();
		for (int k = 0; k < 2; k++) begin
			d = k ? 8'h5a : 8'hc6;
			fork
				peer.feed(d);
				wr(SC, k ? 8'h30 : 8'h10);
			join
			repeat (20) @(posedge core_clk);
			rdc(SC, k ? 8'h31 : 8'h11);
			wr(SC, 8'h00);
			rdc(DB, d);
		end
		$display("test sync receive done");
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		#1;
		t_regs();
		t_tx();
		t_rx();
		t_fe();
		t_m0();
		t_m0rx();
		tally_and_finish();
	end
endmodule
